// ===== inc/orc_pkg.sv
// Purpose: constants and types for the oscillator and reference clock block
// Assumes: 125 MHz hclk, AHB-Lite register access, one aligned word each
// Notes: the unlock keys are arbitrary values
//
// Summary of operation
// RULE1 - USB clock select bit 2: 1 uses fast RC, 0 primary or USB PLL.
// RULE2 - Bit 1 enables the secondary oscillator when set, disables it when clear.
// RULE3 - Writing 1 to bit 0 starts a source switch; hardware clears it when done.
// RULE4 - Oscillator control writes are ignored unless the unlock sequence came first.
// RULE5 - Reference source codes 0 to 8 select clocks; codes 9 to 15 reserved.
// RULE6 - Software must not change source or divider while active reads 1.
// RULE7 - With reference enabled, divider writes wait for the divider switch request.
// RULE8 - Trim register holds a 9-bit value in bits 31-23, reset 0, rest zero.
// RULE9 - With reference enabled, trim writes wait for the divider switch request.
// RULE10 - Pending divider and trim apply together on request, then request clears.
package orc_pkg;

    // Register byte addresses
    localparam logic [7:0] ORC_ADDR_OSC = 8'h00;
    localparam logic [7:0] ORC_ADDR_REFCON = 8'h04;
    localparam logic [7:0] ORC_ADDR_TRIM = 8'h08;
    localparam logic [7:0] ORC_ADDR_UNLOCK = 8'h0C;

    // Oscillator control fields
    localparam int ORC_OSC_SWREQ_BIT = 0;
    localparam int ORC_OSC_SOSC_BIT = 1;
    localparam int ORC_OSC_USBRC_BIT = 2;
    localparam int ORC_OSC_NEWSRC_LSB = 8;
    localparam int ORC_OSC_CURSRC_LSB = 12;

    // Reference control fields
    localparam int ORC_REF_SRC_LSB = 0;
    localparam int ORC_REF_ACTIVE_BIT = 8;
    localparam int ORC_REF_DIVSW_BIT = 9;
    localparam int ORC_REF_EN_BIT = 15;
    localparam int ORC_REF_DIV_LSB = 16;
    localparam int ORC_TRIM_LSB = 23;

    // Reset values
    localparam logic [2:0] ORC_RST_SRC = 3'h0;
    localparam logic [3:0] ORC_RST_REFSRC = 4'h0;
    localparam logic [14:0] ORC_RST_DIV = 15'h0000;
    localparam logic [8:0] ORC_RST_TRIM = 9'h000;

    // Unlock keys, values arbitrary
    localparam logic [31:0] ORC_UNLOCK_KEY1 = 32'h5A5A0001;
    localparam logic [31:0] ORC_UNLOCK_KEY2 = 32'hA5A50002;

    // Oscillator switch settle time
    localparam int ORC_CLK_MHZ = 125;
    localparam int ORC_SWITCH_NS = 1000;
    localparam int ORC_SWITCH_CYC = (ORC_SWITCH_NS * ORC_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] ORC_SWITCH_LOAD = 8'(ORC_SWITCH_CYC - 1);

    typedef enum logic [3:0] {
        ORC_REF_SYSTEM_CLOCK = 4'h0,
        ORC_REF_PERIPHERAL_BUS_CLOCK = 4'h1,
        ORC_REF_PRIMARY_OSCILLATOR = 4'h2,
        ORC_REF_FAST_RC_OSCILLATOR = 4'h3,
        ORC_REF_LOW_POWER_RC_OSCILLATOR = 4'h4,
        ORC_REF_SECONDARY_OSC = 4'h5,
        ORC_REF_USB_PLL = 4'h6,
        ORC_REF_SYSTEM_PLL = 4'h7,
        ORC_REF_INPUT_PIN = 4'h8
    } orc_ref_src_t;

    typedef enum logic [1:0] {
        ORC_LOCKED = 2'b00,
        ORC_KEY1_SEEN = 2'b01,
        ORC_OPEN = 2'b10
    } orc_unlock_t;

endpackage

// ===== rtl/orc_switch_timer.sv
// Purpose: times an oscillator source switch
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes: done pulses once after the settle count
`timescale 1ns/1ps
`default_nettype none
module orc_switch_timer
    import orc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    output logic busy,
    output logic done
);

    typedef struct packed {
        logic busy;
        logic done;
        logic [7:0] cnt;
    } orc_tmr_t;

    orc_tmr_t st;
    orc_tmr_t next_st;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (st.busy) begin
            if (st.cnt == 8'h00) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.cnt = st.cnt - 8'h01;
            end
        end else if (start) begin
            next_st.busy = 1'b1;
            next_st.cnt = ORC_SWITCH_LOAD;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy = st.busy;
    assign done = st.done;

    ////////////////////////////////////////////////////////////////////////
    property p_switch_settle;
        @(posedge hclk) disable iff (!hresetn)
        (start && !busy) |-> ##126 done;
    endproperty
    a_switch_settle: assert property (p_switch_settle) // RULE3
        else $error("switch did not complete after settle count");

endmodule
`default_nettype wire

// ===== rtl/orc_top.sv
// Purpose: oscillator control and reference clock control registers
// Assumes: single AHB-Lite master, word transfers only
// Notes: reads take one wait state, writes none
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module orc_top
    import orc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic ref_active_in,
    output logic usb_clock_from_rc,
    output logic secondary_osc_enable,
    output logic [2:0] system_clock_source,
    output logic ref_output_enable,
    output logic [3:0] ref_source_select,
    output logic [14:0] ref_divider,
    output logic [8:0] ref_trim_value
);

    typedef struct packed {
        logic dph_valid;
        logic dph_write;
        logic rd_pend;
        logic [7:0] dph_addr;
        logic [31:0] rdata;
        orc_unlock_t unlock;
        logic usb_rc;
        logic sosc_en;
        logic osw_req;
        logic [2:0] new_src;
        logic [2:0] sw_target;
        logic [2:0] cur_src;
        logic ref_en;
        logic divsw_req;
        logic [3:0] ref_src;
        logic [14:0] div_sh;
        logic [14:0] div_act;
        logic [8:0] trim_sh;
        logic [8:0] trim_act;
        logic act_s1;
        logic act_s2;
        logic act_s3;
        logic active;
    } orc_state_t;

    orc_state_t st;
    orc_state_t next_st;
    logic sw_start;
    logic sw_busy;
    logic sw_done;
    logic wr_en;
    logic wr_osc;
    logic wr_ref;
    logic wr_trim;
    logic wr_unlock;
    logic osc_open;

    ////////////////////////////////////////////////////////////////////////
    // Data-phase write strobes
    assign wr_en = st.dph_valid && st.dph_write;
    assign wr_osc = wr_en && (st.dph_addr == ORC_ADDR_OSC);
    assign wr_ref = wr_en && (st.dph_addr == ORC_ADDR_REFCON);
    assign wr_trim = wr_en && (st.dph_addr == ORC_ADDR_TRIM);
    assign wr_unlock = wr_en && (st.dph_addr == ORC_ADDR_UNLOCK);
    // RULE4 unlock gate
    assign osc_open = wr_osc && (st.unlock == ORC_OPEN);
    // RULE3 switch start
    assign sw_start = osc_open && hwdata[ORC_OSC_SWREQ_BIT] && !sw_busy;

    orc_switch_timer u_switch_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(sw_start),
        .busy(sw_busy),
        .done(sw_done)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [31:0] rv;
        rv = 32'h00000000;
        next_st = st;

        // Bus address phase
        if (hready) begin
            next_st.dph_valid = hsel && htrans[1] && (hsize == 3'b010);
            next_st.dph_write = hwrite;
            next_st.dph_addr = haddr[7:0];
            next_st.rd_pend = hsel && htrans[1] && !hwrite;
        end else begin
            next_st.rd_pend = 1'b0;
        end

        // Read value, taken during the wait state
        case (st.dph_addr)
            ORC_ADDR_OSC: begin
                rv[ORC_OSC_USBRC_BIT] = st.usb_rc;
                rv[ORC_OSC_SOSC_BIT] = st.sosc_en;
                rv[ORC_OSC_SWREQ_BIT] = st.osw_req;
                rv[ORC_OSC_NEWSRC_LSB +: 3] = st.new_src;
                rv[ORC_OSC_CURSRC_LSB +: 3] = st.cur_src;
            end
            ORC_ADDR_REFCON: begin
                rv[ORC_REF_SRC_LSB +: 4] = st.ref_src;
                rv[ORC_REF_ACTIVE_BIT] = st.active;
                rv[ORC_REF_DIVSW_BIT] = st.divsw_req;
                rv[ORC_REF_EN_BIT] = st.ref_en;
                rv[ORC_REF_DIV_LSB +: 15] = st.div_sh;
            end
            // RULE8 trim readback
            ORC_ADDR_TRIM: begin
                rv[ORC_TRIM_LSB +: 9] = st.trim_sh;
            end
            ORC_ADDR_UNLOCK: begin
                rv[0] = (st.unlock == ORC_OPEN);
            end
            default: begin
                rv = 32'h00000000;
            end
        endcase
        // Non-word reads return zero
        if (st.rd_pend) begin
            next_st.rdata = st.dph_valid ? rv : 32'h00000000;
        end

        // RULE4 unlock sequence
        if (wr_unlock) begin
            if (hwdata == ORC_UNLOCK_KEY1) begin
                next_st.unlock = ORC_KEY1_SEEN;
            end else if (hwdata == ORC_UNLOCK_KEY2
                         && st.unlock == ORC_KEY1_SEEN) begin
                next_st.unlock = ORC_OPEN;
            end else begin
                next_st.unlock = ORC_LOCKED;
            end
        end else if (wr_osc) begin
            next_st.unlock = ORC_LOCKED;
        end

        if (osc_open) begin
            // RULE1 USB source
            next_st.usb_rc = hwdata[ORC_OSC_USBRC_BIT];
            // RULE2 secondary enable
            next_st.sosc_en = hwdata[ORC_OSC_SOSC_BIT];
            next_st.new_src = hwdata[ORC_OSC_NEWSRC_LSB +: 3];
        end

        // RULE3 switch and clear
        if (sw_done) begin
            next_st.osw_req = 1'b0;
            next_st.cur_src = st.sw_target;
        end
        if (sw_start) begin
            next_st.osw_req = 1'b1;
            next_st.sw_target = hwdata[ORC_OSC_NEWSRC_LSB +: 3];
        end

        // RULE10 apply together
        if (st.divsw_req || !st.ref_en) begin
            next_st.div_act = st.div_sh;
            next_st.trim_act = st.trim_sh;
            next_st.divsw_req = 1'b0;
        end

        if (wr_ref) begin
            next_st.ref_en = hwdata[ORC_REF_EN_BIT];
            // RULE5 reserved codes
            if (hwdata[ORC_REF_SRC_LSB +: 4] <= ORC_REF_INPUT_PIN) begin
                next_st.ref_src = hwdata[ORC_REF_SRC_LSB +: 4];
            end
            // RULE7 divider held
            next_st.div_sh = hwdata[ORC_REF_DIV_LSB +: 15];
            if (hwdata[ORC_REF_DIVSW_BIT]) begin
                next_st.divsw_req = 1'b1;
            end
        end
        // RULE9 trim held
        if (wr_trim) begin
            next_st.trim_sh = hwdata[ORC_TRIM_LSB +: 9];
        end

        // Active status from the reference clock domain
        next_st.act_s1 = ref_active_in;
        next_st.act_s2 = st.act_s1;
        next_st.act_s3 = st.act_s2;
        if (st.act_s2 == st.act_s3) begin
            next_st.active = st.act_s3;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.unlock <= ORC_LOCKED;
            st.new_src <= ORC_RST_SRC;
            st.sw_target <= ORC_RST_SRC;
            st.cur_src <= ORC_RST_SRC;
            st.ref_src <= ORC_RST_REFSRC;
            st.div_sh <= ORC_RST_DIV;
            st.div_act <= ORC_RST_DIV;
            st.trim_sh <= ORC_RST_TRIM;
            st.trim_act <= ORC_RST_TRIM;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign hreadyout = !st.rd_pend;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign usb_clock_from_rc = st.usb_rc;
    assign secondary_osc_enable = st.sosc_en;
    assign system_clock_source = st.cur_src;
    assign ref_output_enable = st.ref_en;
    assign ref_source_select = st.ref_src;
    assign ref_divider = st.div_act;
    assign ref_trim_value = st.trim_act;

    ////////////////////////////////////////////////////////////////////////
    property p_usb_src;
        @(posedge hclk) disable iff (!hresetn)
        osc_open |=> usb_clock_from_rc == $past(hwdata[ORC_OSC_USBRC_BIT]);
    endproperty
    a_usb_src: assert property (p_usb_src) // RULE1
        else $error("USB source bit not taken from write");

    property p_sosc_en;
        @(posedge hclk) disable iff (!hresetn)
        osc_open |=> secondary_osc_enable == $past(hwdata[ORC_OSC_SOSC_BIT]);
    endproperty
    a_sosc_en: assert property (p_sosc_en) // RULE2
        else $error("secondary enable not taken from write");

    property p_switch_clear;
        @(posedge hclk) disable iff (!hresetn)
        sw_start |=> st.osw_req ##[120:130] !st.osw_req;
    endproperty
    a_switch_clear: assert property (p_switch_clear) // RULE3
        else $error("switch request not cleared after completion");

    property p_locked_write;
        @(posedge hclk) disable iff (!hresetn)
        (wr_osc && st.unlock != ORC_OPEN) |=>
            $stable(usb_clock_from_rc) && $stable(secondary_osc_enable)
            && $stable(st.new_src) && !$rose(st.osw_req);
    endproperty
    a_locked_write: assert property (p_locked_write) // RULE4
        else $error("locked oscillator write took effect");

    property p_relock;
        @(posedge hclk) disable iff (!hresetn)
        wr_osc |=> st.unlock == ORC_LOCKED;
    endproperty
    a_relock: assert property (p_relock) // RULE4
        else $error("unlock not consumed by oscillator write");

    property p_ref_src_legal;
        @(posedge hclk) disable iff (!hresetn)
        ref_source_select <= ORC_REF_INPUT_PIN;
    endproperty
    a_ref_src_legal: assert property (p_ref_src_legal) // RULE5
        else $error("reserved reference source selected");

    property p_div_held;
        @(posedge hclk) disable iff (!hresetn)
        (wr_ref && st.ref_en && !st.divsw_req
            && !hwdata[ORC_REF_DIVSW_BIT]) |=> $stable(ref_divider);
    endproperty
    a_div_held: assert property (p_div_held) // RULE7
        else $error("divider changed without switch request");

    property p_trim_held;
        @(posedge hclk) disable iff (!hresetn)
        (wr_trim && st.ref_en && !st.divsw_req) |=> $stable(ref_trim_value);
    endproperty
    a_trim_held: assert property (p_trim_held) // RULE9
        else $error("trim changed without switch request");

    property p_apply_both;
        @(posedge hclk) disable iff (!hresetn)
        (wr_ref && st.ref_en && hwdata[ORC_REF_DIVSW_BIT]) |=>
            st.divsw_req ##1 (!st.divsw_req
            && ref_divider == $past(st.div_sh)
            && ref_trim_value == $past(st.trim_sh));
    endproperty
    a_apply_both: assert property (p_apply_both) // RULE10
        else $error("pending divider and trim not applied together");

    property p_trim_read;
        @(posedge hclk) disable iff (!hresetn)
        (st.rd_pend && st.dph_addr == ORC_ADDR_TRIM) |=>
            hrdata[22:0] == 23'h000000;
    endproperty
    a_trim_read: assert property (p_trim_read) // RULE8
        else $error("unimplemented trim bits read nonzero");

endmodule
`default_nettype wire

// ===== testbench/tb_osc_and_refclk_control.sv
// Purpose: self-checking bench for the oscillator and reference clock block
// Assumes: one AHB-Lite master, hready looped back from hreadyout
// Notes: reference active input stays low while source or divider change
`timescale 1ns/1ps
`default_nettype none
module tb_osc_and_refclk_control;
    import orc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, ref_active_in;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hready;
    logic hreadyout, hresp, usb_clock_from_rc, secondary_osc_enable;
    logic [31:0] hrdata;
    logic [2:0] system_clock_source;
    logic ref_output_enable;
    logic [3:0] ref_source_select;
    logic [14:0] ref_divider;
    logic [8:0] ref_trim_value;
    int bad_count = 0;
    int samples_checked = 0;
    logic [2:0] xsize = 3'b010;

    assign hready = hreadyout;

    orc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .ref_active_in(ref_active_in),
        .usb_clock_from_rc(usb_clock_from_rc),
        .secondary_osc_enable(secondary_osc_enable),
        .system_clock_source(system_clock_source),
        .ref_output_enable(ref_output_enable),
        .ref_source_select(ref_source_select), .ref_divider(ref_divider),
        .ref_trim_value(ref_trim_value));

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bounded wait for hready sampled high
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 20) begin
            n++;
            @(posedge hclk);
        end
        if (n >= 20) begin
            check("hready", {31'h0, hready}, 32'h1);
        end
    endtask

    task automatic xfer(input logic wr_en, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr_en;
        hsize <= xsize;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        check(what, r, exp);
    endtask

    task automatic unlock();
        wr(ORC_ADDR_UNLOCK, ORC_UNLOCK_KEY1);
        wr(ORC_ADDR_UNLOCK, ORC_UNLOCK_KEY2);
    endtask

    function automatic logic [31:0] refcon(input logic [14:0] div,
        input logic en, input logic sw, input logic [3:0] src);
        return {1'b0, div, en, 5'h00, sw, 1'b0, 4'h0, src};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        check("outs", {13'h0, usb_clock_from_rc, secondary_osc_enable,
            system_clock_source, ref_output_enable, ref_source_select,
            ref_trim_value}, 32'h0);
        check("div", {17'h0, ref_divider}, 32'h0);
        rd_chk("osc", ORC_ADDR_OSC, 32'h0);
        rd_chk("refcon", ORC_ADDR_REFCON, 32'h0);
        rd_chk("trim", ORC_ADDR_TRIM, 32'h0);
        rd_chk("unmapped", 8'h40, 32'h0);
        check("hresp", {31'h0, hresp}, 32'h0);
        // Byte-sized transfers are dropped and read as zero
        xsize = 3'b000;
        wr(ORC_ADDR_TRIM, 32'hFFFFFFFF);
        rd_chk("byte read", ORC_ADDR_TRIM, 32'h0);
        xsize = 3'b010;
        rd_chk("byte write", ORC_ADDR_TRIM, 32'h0);
        $display("reset test done");
    endtask

    task automatic test_lock();
        wr(ORC_ADDR_OSC, 32'h6);
        repeat (2) @(posedge hclk);
        check("locked", {31'h0, usb_clock_from_rc}, 32'h0);
        unlock();
        rd_chk("open", ORC_ADDR_UNLOCK, 32'h1);
        wr(ORC_ADDR_OSC, 32'h6);
        repeat (2) @(posedge hclk);
        check("usb rc", {31'h0, usb_clock_from_rc}, 32'h1);
        check("sosc on", {31'h0, secondary_osc_enable}, 32'h1);
        wr(ORC_ADDR_OSC, 32'h0);
        rd_chk("relock", ORC_ADDR_OSC, 32'h6);
        unlock();
        wr(ORC_ADDR_OSC, 32'h2);
        repeat (2) @(posedge hclk);
        check("usb main", {31'h0, usb_clock_from_rc}, 32'h0);
        check("sosc kept", {31'h0, secondary_osc_enable}, 32'h1);
        unlock();
        wr(ORC_ADDR_OSC, 32'h0);
        repeat (2) @(posedge hclk);
        check("sosc off", {31'h0, secondary_osc_enable}, 32'h0);
        $display("lock test done");
    endtask

    task automatic test_switch();
        unlock();
        wr(ORC_ADDR_OSC, 32'h0503);
        rd_chk("switching", ORC_ADDR_OSC, 32'h0503);
        repeat (100) @(posedge hclk);
        check("src wait", {29'h0, system_clock_source}, 32'h0);
        repeat (40) @(posedge hclk);
        check("src new", {29'h0, system_clock_source}, 32'h5);
        rd_chk("switched", ORC_ADDR_OSC, 32'h5502);
        $display("switch test done");
    endtask

    task automatic test_source();
        for (int i = 0; i < 16; i++) begin
            wr(ORC_ADDR_REFCON, refcon(15'h0, 1'b0, 1'b0, 4'(i)));
            repeat (2) @(posedge hclk);
            check("source", {28'h0, ref_source_select},
                (i < 9) ? 32'(i) : 32'h8);
        end
        $display("source test done");
    endtask

    task automatic test_divider();
        wr(ORC_ADDR_REFCON, refcon(15'h0003, 1'b0, 1'b0, 4'h2));
        repeat (2) @(posedge hclk);
        check("div direct", {17'h0, ref_divider}, 32'h3);
        wr(ORC_ADDR_REFCON, refcon(15'h0003, 1'b1, 1'b0, 4'h2));
        wr(ORC_ADDR_REFCON, refcon(15'h1234, 1'b1, 1'b0, 4'h2));
        wr(ORC_ADDR_TRIM, {9'h1AB, 23'h0});
        repeat (3) @(posedge hclk);
        check("div held", {17'h0, ref_divider}, 32'h3);
        check("trim held", {23'h0, ref_trim_value}, 32'h0);
        check("ref en", {31'h0, ref_output_enable}, 32'h1);
        rd_chk("trim pend", ORC_ADDR_TRIM, {9'h1AB, 23'h0});
        wr(ORC_ADDR_REFCON, refcon(15'h1234, 1'b1, 1'b1, 4'h2));
        repeat (2) @(posedge hclk);
        check("div set", {17'h0, ref_divider}, 32'h1234);
        check("trim set", {23'h0, ref_trim_value}, 32'h1AB);
        rd_chk("req clear", ORC_ADDR_REFCON,
            refcon(15'h1234, 1'b1, 1'b0, 4'h2));
        wr(ORC_ADDR_REFCON, refcon(15'h1234, 1'b0, 1'b0, 4'h2));
        wr(ORC_ADDR_TRIM, 32'hFFFFFFFF);
        repeat (2) @(posedge hclk);
        check("trim free", {23'h0, ref_trim_value}, 32'h1FF);
        check("ref off", {31'h0, ref_output_enable}, 32'h0);
        rd_chk("trim bits", ORC_ADDR_TRIM, 32'hFF800000);
        $display("divider test done");
    endtask

    task automatic test_active();
        ref_active_in <= 1'b1;
        repeat (6) @(posedge hclk);
        rd_chk("active", ORC_ADDR_REFCON,
            refcon(15'h1234, 1'b0, 1'b0, 4'h2) | 32'h100);
        ref_active_in <= 1'b0;
        repeat (6) @(posedge hclk);
        rd_chk("inactive", ORC_ADDR_REFCON,
            refcon(15'h1234, 1'b0, 1'b0, 4'h2));
        $display("active test done");
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        ref_active_in = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        test_reset();
        test_lock();
        test_switch();
        test_source();
        test_divider();
        test_active();
        print_verdict();
    end

    initial begin
        #(8 * 20000);
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
